// ==== verilog/tid_defs.svh ====
`ifndef TID_DEFS_SVH
`define TID_DEFS_SVH

// instruction codes
`define TID_IR_W 5
`define TID_IR_IDCODE 5'h01
`define TID_IR_IMPL 5'h03
`define TID_IR_ADDR 5'h08
`define TID_IR_DATA 5'h09
`define TID_IR_CTRL 5'h0A
`define TID_IR_ALL 5'h0B
`define TID_IR_DBG_BOOT 5'h0C
`define TID_IR_NORM_BOOT 5'h0D
`define TID_IR_FAST 5'h0E
`define TID_IR_TRACE_A 5'h10
`define TID_IR_TRACE_B 5'h11
`define TID_IR_TRACE_D 5'h12
`define TID_IR_BYPASS 5'h1F

// scan path lengths
`define TID_CHAIN_W 96
`define TID_LEN_BYP 7'h01
`define TID_LEN_WORD 7'h20
`define TID_LEN_FAST 7'h21
`define TID_LEN_ALL 7'h60

// register offsets
`define TID_OFS_CTRL 8'h00
`define TID_OFS_STATUS 8'h04
`define TID_OFS_ADDR 8'h08
`define TID_OFS_DATA 8'h0C
`define TID_OFS_ECTRL 8'h10
`define TID_OFS_FAST 8'h14
`define TID_OFS_TRA 8'h18
`define TID_OFS_TRB 8'h1C
`define TID_OFS_TRD 8'h20
`define TID_OFS_TRD_W 8'h24
`define TID_OFS_ID 8'h28
`define TID_OFS_IMPL 8'h2C

// field positions
`define TID_CTRL_TRACE_BIT 0
`define TID_CTRL_RSTREQ_BIT 1
`define TID_CTRL_DBGEXIT_BIT 2
`define TID_ST_BOOT_BIT 8
`define TID_ST_DBG_BIT 9
`define TID_EC_BRK_BIT 12
`define TID_EC_TRAP_BIT 14
`define TID_EC_PEN_BIT 15

// reset values
`define TID_TRACE_RST 1'b1
`define TID_TRD_W_RST 5'h1F
`define TID_IDCODE_DEF 32'h00001001
`define TID_IMPL_DEF 32'h40004000

`endif

// ==== verilog/tid_pkg.sv ====
package tid_pkg;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tid_state_t;

  typedef enum logic [3:0] {
    SEL_BYPASS, SEL_ID, SEL_IMPL, SEL_ADDR, SEL_DATA, SEL_CTRL, SEL_ALL, SEL_FAST,
    SEL_TRA, SEL_TRB, SEL_TRD
  } tid_sel_t;

endpackage

// ==== verilog/tid_sync.sv ====
`timescale 1ns/1ns
module tid_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous levels in, synchronised out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule

// ==== verilog/tid_top.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - a five-bit instruction shifts in during shift-IR and picks the data path
// - any code not decoded acts exactly as bypass
// - all-ones code selects the one-bit bypass register
// - code 01 selects the 32-bit identification register
// - identification is selected right after any TAP reset
// - code 03 selects the 32-bit implementation register
// - code 08 selects the 32-bit address register, captured then shifted
// - code 09 selects the 32-bit data register, captured then shifted
// - code 0A selects the 32-bit debug control register
// - code 0B chains address, data, control; bit 0 leaves first
// - code 0C after update-IR makes the three probe bits reset to 1
// - boot flag holds until normal boot, test reset, or tck in reset state
// - with boot flag set, a core reset enters debug mode directly
// - debug boot code routes data scans through bypass
// - code 0D clears the boot flag and routes scans through bypass
// - code 0E chains data register and one-bit fast-data register
// - codes 10-12 select trace registers, or bypass without trace block
// - trace access path length follows the accessed trace register width
// - test-logic-reset and capture-IR load 00001 into the instruction shifter
// - a new instruction governs scans from the next data scan on
// - capture and shift on tck rise, tdo changes on tck fall
`include "tid_defs.svh"
module tid_top import tid_pkg::*; #(
  parameter logic [31:0] ID_VALUE = `TID_IDCODE_DEF, // arbitrary identification value
  parameter logic [31:0] IMPL_VALUE = `TID_IMPL_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  // core side
  output logic boot_debug,
  output logic debug_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and tck edges

  logic [3:0] pins_s;
  logic tck_d_r;
  logic tck_s, tms_s, tdi_s, trst_s, tck_rise, tck_fall;

  tid_sync #(.WIDTH(4)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din({trst_n, tdi, tms, tck}),
    .dout(pins_s)
  );

  assign tck_s = pins_s[0];
  assign tms_s = pins_s[1];
  assign tdi_s = pins_s[2];
  assign trst_s = pins_s[3];
  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controller

  tid_state_t tap_state_r;

  function automatic tid_state_t tap_next(input tid_state_t s, input logic m);
    case (s)
      ST_RESET: tap_next = m ? ST_RESET : ST_IDLE;
      ST_IDLE: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: tap_next = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: tap_next = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: tap_next = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: tap_next = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: tap_next = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: tap_next = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: tap_next = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: tap_next = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      default: tap_next = ST_RESET;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_state_r <= ST_RESET;
    end else if (!trst_s) begin
      tap_state_r <= ST_RESET;
    end else if (tck_rise) begin
      tap_state_r <= tap_next(tap_state_r, tms_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction shifter and update latch

  logic [4:0] ir_shift_r;
  logic [4:0] ir_latch_r;
  logic trace_present_r;
  tid_sel_t dr_sel;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_shift_r <= `TID_IR_IDCODE;
    end else if (!trst_s) begin
      ir_shift_r <= `TID_IR_IDCODE;
    end else if (tck_rise) begin
      if (tap_state_r == ST_RESET || tap_state_r == ST_CAP_IR) begin
        ir_shift_r <= `TID_IR_IDCODE;
      end else if (tap_state_r == ST_SHIFT_IR) begin
        ir_shift_r <= {tdi_s, ir_shift_r[4:1]};
      end
    end
  end

  // latch moves only on update-IR or in test-logic-reset, so the path holds while a new code shifts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir_latch_r <= `TID_IR_IDCODE;
    end else if (!trst_s) begin
      ir_latch_r <= `TID_IR_IDCODE;
    end else if (tck_rise) begin
      if (tap_state_r == ST_RESET) begin
        ir_latch_r <= `TID_IR_IDCODE;
      end else if (tap_state_r == ST_UPD_IR) begin
        ir_latch_r <= ir_shift_r;
      end
    end
  end

  function automatic tid_sel_t decode(input logic [4:0] ir, input logic trace);
    case (ir)
      `TID_IR_IDCODE: decode = SEL_ID;
      `TID_IR_IMPL: decode = SEL_IMPL;
      `TID_IR_ADDR: decode = SEL_ADDR;
      `TID_IR_DATA: decode = SEL_DATA;
      `TID_IR_CTRL: decode = SEL_CTRL;
      `TID_IR_ALL: decode = SEL_ALL;
      `TID_IR_FAST: decode = SEL_FAST;
      `TID_IR_TRACE_A: decode = trace ? SEL_TRA : SEL_BYPASS;
      `TID_IR_TRACE_B: decode = trace ? SEL_TRB : SEL_BYPASS;
      `TID_IR_TRACE_D: decode = trace ? SEL_TRD : SEL_BYPASS;
      // boot codes, all-ones and every other code fall here
      default: decode = SEL_BYPASS;
    endcase
  endfunction

  assign dr_sel = decode(ir_latch_r, trace_present_r);

  ////////////////////////////////////////////////////////////////////////////
  // data scan chain

  logic [`TID_CHAIN_W-1:0] dr_shift_r;
  logic [`TID_CHAIN_W-1:0] dr_shift_nxt;
  logic [`TID_CHAIN_W-1:0] cap_val;
  logic [6:0] dr_len;
  logic [31:0] addr_r, data_r, ectrl_r, tra_r, trb_r, trd_r, trd_mask;
  logic fast_r;
  logic [4:0] trd_w_r;

  assign trd_mask = 32'hFFFFFFFF >> (5'h1F - trd_w_r);

  always_comb begin
    case (dr_sel)
      SEL_BYPASS: dr_len = `TID_LEN_BYP;
      SEL_ALL: dr_len = `TID_LEN_ALL;
      SEL_FAST: dr_len = `TID_LEN_FAST;
      SEL_TRD: dr_len = {2'b00, trd_w_r} + 7'h01;
      default: dr_len = `TID_LEN_WORD;
    endcase
  end

  always_comb begin
    cap_val = '0;
    case (dr_sel)
      SEL_ID: cap_val[31:0] = ID_VALUE;
      SEL_IMPL: cap_val[31:0] = IMPL_VALUE;
      SEL_ADDR: cap_val[31:0] = addr_r;
      SEL_DATA: cap_val[31:0] = data_r;
      SEL_CTRL: cap_val[31:0] = ectrl_r;
      SEL_ALL: cap_val = {ectrl_r, data_r, addr_r};
      SEL_FAST: cap_val[32:0] = {data_r, fast_r};
      SEL_TRA: cap_val[31:0] = tra_r;
      SEL_TRB: cap_val[31:0] = trb_r;
      SEL_TRD: cap_val[31:0] = trd_r & trd_mask;
      default: cap_val = '0;
    endcase
  end

  // tdi enters at the top of the active length, bit 0 leaves toward tdo
  always_comb begin
    dr_shift_nxt = dr_shift_r;
    for (int i = 0; i < `TID_CHAIN_W; i++) begin
      if (i == int'(dr_len) - 1) begin
        dr_shift_nxt[i] = tdi_s;
      end else if (i < int'(dr_len) - 1) begin
        dr_shift_nxt[i] = dr_shift_r[i+1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dr_shift_r <= '0;
    end else if (tck_rise) begin
      if (tap_state_r == ST_CAP_DR) begin
        dr_shift_r <= cap_val;
      end else if (tap_state_r == ST_SHIFT_DR) begin
        dr_shift_r <= dr_shift_nxt;
      end
    end
  end

  // tdo and its enable move on the falling edge only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= (tap_state_r == ST_SHIFT_IR) ? ir_shift_r[0] : dr_shift_r[0];
      tdo_oe <= (tap_state_r == ST_SHIFT_IR) || (tap_state_r == ST_SHIFT_DR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot indication and debug entry

  logic upd_dr, rst_req, dbg_exit;

  assign upd_dr = tck_rise && (tap_state_r == ST_UPD_DR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_debug <= 1'b0;
    end else if (!trst_s || (tck_rise && tap_state_r == ST_RESET)) begin
      boot_debug <= 1'b0;
    end else if (tck_rise && tap_state_r == ST_UPD_IR) begin
      if (ir_shift_r == `TID_IR_DBG_BOOT) begin
        boot_debug <= 1'b1;
      end else if (ir_shift_r == `TID_IR_NORM_BOOT) begin
        boot_debug <= 1'b0;
      end
    end
  end

  // entry on the reset request beats a simultaneous exit request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_mode <= 1'b0;
    end else if (rst_req) begin
      debug_mode <= boot_debug;
    end else if (dbg_exit) begin
      debug_mode <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states

  logic wr_pend_r;
  logic [7:0] wr_ofs_r;
  logic addr_ok, bus_wr;

  assign addr_ok = hsel && htrans[1] && hready;
  assign bus_wr = wr_pend_r;
  assign rst_req = bus_wr && (wr_ofs_r == `TID_OFS_CTRL) && hwdata[`TID_CTRL_RSTREQ_BIT];
  assign dbg_exit = bus_wr && (wr_ofs_r == `TID_OFS_CTRL) && hwdata[`TID_CTRL_DBGEXIT_BIT];

  function automatic logic wr_hit(input logic pend, input logic [7:0] ofs, input logic [7:0] t);
    wr_hit = pend && (ofs == t);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= addr_ok && hwrite && (haddr[31:8] == 24'h000000);
      wr_ofs_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= 32'h00000000;
      if (haddr[31:8] == 24'h000000) begin
        case (haddr[7:0])
          `TID_OFS_CTRL: hrdata[`TID_CTRL_TRACE_BIT] <= trace_present_r;
          `TID_OFS_STATUS: hrdata <= {12'h000, dr_sel, tap_state_r, 2'h0,
                                      debug_mode, boot_debug, 3'h0, ir_latch_r};
          `TID_OFS_ADDR: hrdata <= addr_r;
          `TID_OFS_DATA: hrdata <= data_r;
          `TID_OFS_ECTRL: hrdata <= ectrl_r;
          `TID_OFS_FAST: hrdata[0] <= fast_r;
          `TID_OFS_TRA: hrdata <= tra_r;
          `TID_OFS_TRB: hrdata <= trb_r;
          `TID_OFS_TRD: hrdata <= trd_r;
          `TID_OFS_TRD_W: hrdata[4:0] <= trd_w_r;
          `TID_OFS_ID: hrdata <= ID_VALUE;
          `TID_OFS_IMPL: hrdata <= IMPL_VALUE;
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file; update-DR has priority over a bus write in the same cycle, except a reset request, which beats it for ectrl_r

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trace_present_r <= `TID_TRACE_RST;
      trd_w_r <= `TID_TRD_W_RST;
    end else begin
      if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_CTRL)) begin
        trace_present_r <= hwdata[`TID_CTRL_TRACE_BIT];
      end
      if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_TRD_W)) begin
        trd_w_r <= hwdata[4:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 32'h00000000;
      data_r <= 32'h00000000;
      fast_r <= 1'b0;
    end else if (upd_dr) begin
      if (dr_sel == SEL_ADDR || dr_sel == SEL_ALL) begin
        addr_r <= dr_shift_r[31:0];
      end
      if (dr_sel == SEL_DATA) begin
        data_r <= dr_shift_r[31:0];
      end else if (dr_sel == SEL_ALL) begin
        data_r <= dr_shift_r[63:32];
      end else if (dr_sel == SEL_FAST) begin
        data_r <= dr_shift_r[32:1];
        fast_r <= dr_shift_r[0];
      end
    end else begin
      if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_ADDR)) begin
        addr_r <= hwdata;
      end
      if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_DATA)) begin
        data_r <= hwdata;
      end
      if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_FAST)) begin
        fast_r <= hwdata[0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ectrl_r <= 32'h00000000;
    end else if (rst_req) begin
      ectrl_r[`TID_EC_TRAP_BIT] <= boot_debug;
      ectrl_r[`TID_EC_PEN_BIT] <= boot_debug;
      ectrl_r[`TID_EC_BRK_BIT] <= boot_debug;
    end else if (upd_dr && (dr_sel == SEL_CTRL)) begin
      ectrl_r <= dr_shift_r[31:0];
    end else if (upd_dr && (dr_sel == SEL_ALL)) begin
      ectrl_r <= dr_shift_r[95:64];
    end else if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_ECTRL)) begin
      ectrl_r <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tra_r <= 32'h00000000;
      trb_r <= 32'h00000000;
      trd_r <= 32'h00000000;
    end else if (upd_dr) begin
      if (dr_sel == SEL_TRA) begin
        tra_r <= dr_shift_r[31:0];
      end
      if (dr_sel == SEL_TRB) begin
        trb_r <= dr_shift_r[31:0];
      end
      if (dr_sel == SEL_TRD) begin
        trd_r <= dr_shift_r[31:0] & trd_mask;
      end
    end else begin
      if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_TRA)) begin
        tra_r <= hwdata;
      end
      if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_TRB)) begin
        trb_r <= hwdata;
      end
      if (wr_hit(bus_wr, wr_ofs_r, `TID_OFS_TRD)) begin
        trd_r <= hwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_cap_ir;
    tck_rise && trst_s && (tap_state_r == ST_CAP_IR);
  endsequence

  sequence s_boot_upd;
    tck_rise && trst_s && (tap_state_r == ST_UPD_IR) && (ir_shift_r == `TID_IR_DBG_BOOT);
  endsequence

  AST_IR_CAPTURE: assert property (s_cap_ir |=> ir_shift_r == 5'h01)
    else $error("capture-IR did not load 00001");
  AST_IR_LOAD: assert property (tck_rise && trst_s && tap_state_r == ST_UPD_IR
    |=> ir_latch_r == $past(ir_shift_r))
    else $error("update-IR did not load the instruction");
  AST_SEL_HOLD: assert property (trst_s && tap_state_r inside {ST_CAP_IR, ST_SHIFT_IR,
    ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR} && $past(trst_s) |=> $stable(ir_latch_r))
    else $error("selection moved during instruction scan");
  AST_UNDECODED_BYPASS: assert property (ir_latch_r inside {5'h00, 5'h02, 5'h0C,
    5'h0D, 5'h1E, 5'h1F} |-> dr_sel == SEL_BYPASS && dr_len == 7'h01)
    else $error("undecoded code not bypass");
  AST_ID_LEN: assert property (ir_latch_r == 5'h01 |-> dr_sel == SEL_ID && dr_len == 7'h20)
    else $error("identification path wrong");
  AST_BOOT_SET: assert property (s_boot_upd |=> boot_debug [*2])
    else $error("debug boot flag not set");
  AST_BOOT_CLR: assert property (tck_rise && tap_state_r == ST_RESET |=> !boot_debug)
    else $error("boot flag survived logic reset");
  AST_TDO_FALL: assert property ($changed(tdo) |-> $past(tck_fall))
    else $error("tdo changed off a falling tck edge");
  AST_DEBUG_ENTRY: assert property (rst_req && boot_debug
    |=> debug_mode && ectrl_r[`TID_EC_PEN_BIT] && ectrl_r[`TID_EC_TRAP_BIT])
    else $error("debug boot reset did not enter debug");
  AST_TRACE_ABSENT: assert property (!trace_present_r && ir_latch_r inside {5'h10, 5'h11,
    5'h12} |-> dr_sel == SEL_BYPASS)
    else $error("trace code without trace block not bypass");
  AST_ALL_ORDER: assert property (tck_rise && tap_state_r == ST_CAP_DR && dr_sel == SEL_ALL
    |=> dr_shift_r[31:0] == $past(addr_r))
    else $error("chain does not start with address bit 0");

endmodule

// ==== dv/tid_probe.sv ====
`timescale 1ns/1ns
module tid_probe (
  // system clock
  input wire logic hclk,
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  logic q;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // tdo read late in the high phase, long after the previous fall moved it
  task automatic step(input logic m, input logic d, output logic o);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge hclk);
    tck <= 1'b1;
    repeat (3) @(posedge hclk);
    @(negedge hclk) o = tdo;
    @(posedge hclk) tck <= 1'b0;
  endtask
  // idle tdi toggles so a stale level never looks valid
  task automatic tlr();
    repeat (5) step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    repeat (8) @(posedge hclk);
  endtask
  task automatic ir_scan(input logic [4:0] c, output logic [4:0] cap);
    step(1'b1, ~tdi, q);
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < 5; i++) step(i == 4, c[i], cap[i]);
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    repeat (8) @(posedge hclk);
  endtask
  task automatic dr_scan(input logic [127:0] din, output logic [127:0] dout);
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    step(1'b0, ~tdi, q);
    for (int i = 0; i < 128; i++) step(i == 127, din[i], dout[i]);
    step(1'b1, ~tdi, q);
    step(1'b0, ~tdi, q);
    repeat (8) @(posedge hclk);
  endtask
  task automatic trst_pulse();
    trst_n <= 1'b0;
    repeat (8) @(posedge hclk);
    trst_n <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask
endmodule

// ==== dv/test_tap_instruction_decoder.sv ====
`timescale 1ns/1ns
`include "tid_defs.svh"
module test_tap_instruction_decoder;
  localparam logic [31:0] ID_V = 32'h0A5C3001; // arbitrary value
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rv, a, d, e, f;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, boot_debug, debug_mode, tr;
  logic [127:0] sh_in, sh_out;
  int seed = 79982;
  int error_cnt = 0;
  int checked = 0;
  int trw = 32;
  int oe_cnt = 0;
  assign hready = hreadyout;
  tid_top #(.ID_VALUE(ID_V)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tck(tck),
    .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .boot_debug(boot_debug),
    .debug_mode(debug_mode));
  tid_probe probe (.hclk(hclk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // drive window counted in hclk cycles, checked once per data scan
  always @(posedge hclk) begin
    if (tdo_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    ahb(1'b1, ad, wd, rv);
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] x);
    ahb(1'b0, ad, 32'h0, rv);
    chk(rv, x);
    chk({31'h0, hresp}, 32'h0);
  endtask
  function automatic int plen(input logic [4:0] c);
    case (c)
      `TID_IR_IDCODE, `TID_IR_IMPL, `TID_IR_ADDR, `TID_IR_DATA, `TID_IR_CTRL: return 32;
      `TID_IR_ALL: return 96;
      `TID_IR_FAST: return 33;
      `TID_IR_TRACE_A, `TID_IR_TRACE_B: return tr ? 32 : 1;
      `TID_IR_TRACE_D: return tr ? trw : 1;
      default: return 1;
    endcase
  endfunction
  // path length shows as the delay before shifted-in bits come back out
  task automatic scan(input int len, input logic [127:0] cap, input int capw);
    logic bad;
    int n;
    bad = 1'b0;
    sh_in = {$random(seed), $random(seed), $random(seed), $random(seed)};
    n = oe_cnt;
    probe.dr_scan(sh_in, sh_out);
    // enable stands from the fall entering shift to the fall leaving it: 128 tck periods
    chk(oe_cnt - n, 32'h400);
    for (int i = 0; i < 128; i++) begin
      if (i < capw && sh_out[i] !== cap[i]) bad = 1'b1;
      if (i >= len && sh_out[i] !== sh_in[i - len]) bad = 1'b1;
    end
    chk({31'h0, bad}, 32'h0);
  endtask
  task automatic code(input logic [4:0] c, input logic [127:0] cap, input int capw);
    logic [4:0] ic;
    probe.ir_scan(c, ic);
    chk({27'h0, ic}, 32'h1);
    scan(plen(c), cap, capw);
  endtask
  task automatic reg_scan(input logic [7:0] ofs, input logic [4:0] c);
    logic [31:0] v;
    v = $random(seed);
    wr(ofs, v);
    code(c, {96'h0, v}, 32);
    rd_chk(ofs, sh_in[127:96]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tr = 1'b1;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wr(8'h30, 32'hFFFFFFFF);
    rd_chk(8'h30, 32'h0);
    rd_chk(`TID_OFS_CTRL, 32'h1);
    rd_chk(`TID_OFS_TRD_W, 32'h1F);
    probe.tlr();
    scan(32, {96'h0, ID_V}, 32);
    code(`TID_IR_IMPL, {96'h0, `TID_IMPL_DEF}, 32);
    code(`TID_IR_IDCODE, {96'h0, ID_V}, 32);
    code(`TID_IR_BYPASS, '0, 0);
    for (int k = 0; k < 8; k++) code(5'($random(seed)), '0, 0);
    reg_scan(`TID_OFS_ADDR, `TID_IR_ADDR);
    reg_scan(`TID_OFS_DATA, `TID_IR_DATA);
    ahb(1'b0, `TID_OFS_ECTRL, 32'h0, e);
    code(`TID_IR_CTRL, {96'h0, e}, 32);
    ahb(1'b0, `TID_OFS_ADDR, 32'h0, a);
    ahb(1'b0, `TID_OFS_DATA, 32'h0, d);
    ahb(1'b0, `TID_OFS_ECTRL, 32'h0, e);
    code(`TID_IR_ALL, {32'h0, e, d, a}, 96);
    ahb(1'b0, `TID_OFS_DATA, 32'h0, d);
    ahb(1'b0, `TID_OFS_FAST, 32'h0, f);
    code(`TID_IR_FAST, {95'h0, d, f[0]}, 33);
    trw = 8;
    wr(`TID_OFS_TRD_W, 32'h7);
    for (int t = 1; t >= 0; t--) begin
      tr = t[0];
      wr(`TID_OFS_CTRL, {31'h0, tr});
      for (int k = 0; k < 3; k++) code(5'(`TID_IR_TRACE_A + k), '0, 0);
    end
    tr = 1'b1;
    code(`TID_IR_DBG_BOOT, '0, 0);
    chk({31'h0, boot_debug}, 32'h1);
    wr(`TID_OFS_CTRL, 32'h3);
    ahb(1'b0, `TID_OFS_ECTRL, 32'h0, e);
    chk({29'h0, e[15], e[14], e[12]}, 32'h7);
    chk({31'h0, debug_mode}, 32'h1);
    wr(`TID_OFS_CTRL, 32'h5);
    code(`TID_IR_NORM_BOOT, '0, 0);
    chk({31'h0, boot_debug}, 32'h0);
    wr(`TID_OFS_CTRL, 32'h3);
    ahb(1'b0, `TID_OFS_ECTRL, 32'h0, e);
    chk({28'h0, debug_mode, e[15], e[14], e[12]}, 32'h0);
    code(`TID_IR_DBG_BOOT, '0, 0);
    probe.tlr();
    chk({31'h0, boot_debug}, 32'h0);
    code(`TID_IR_DBG_BOOT, '0, 0);
    probe.trst_pulse();
    chk({31'h0, boot_debug}, 32'h0);
    probe.tlr();
    scan(32, {96'h0, ID_V}, 32);
    end_sim();
  end
  initial begin
    #600000;
    error_cnt++;
    $display("Error at %0t: timeout", $time);
    end_sim();
  end
endmodule
